// *** rtl/sbc_spi_register_map.sv ***
`timescale 1ns/10ps
`default_nettype none

module sbc_spi_register_map (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic spi_clk_in,
  input wire logic spi_csn_n_in,
  input wire logic spi_sdi_in,
  output logic spi_sdo_out,
  output logic spi_sdo_oe_out,
  input wire logic wake_input_in,
  input wire logic device_quiet_in,
  input wire logic mode_change_in,
  input wire sbc_regs_pkg::sbc_mode_e mode_entered_in,
  input wire logic [sbc_regs_pkg::NUM_STAT-1:0][7:0] status_event_in,
  input wire logic fail_trigger_in,
  input wire logic fail_release_in,
  output logic [sbc_regs_pkg::NUM_CTRL-1:0][7:0] control_regs_out,
  output logic mode_write_out,
  output logic [1:0] can_mode_out,
  output logic [1:0] lin1_mode_out,
  output logic [1:0] lin2_mode_out,
  output logic fail_outputs_out,
  output logic [7:0] summary_out
);
  import sbc_regs_pkg::*;

  typedef struct packed {
    logic [NUM_CTRL-1:0][7:0] ctrl;
    logic [NUM_STAT-1:0][7:0] stat;
    logic fail_latch;
    sbc_mode_e cur_mode;
    logic mode_write;
  } regmap_s;

  regmap_s state_r;
  regmap_s state_nxt;

  logic [3:0] pins_sync;
  logic sclk_s;
  logic csn_s;
  logic sdi_s;
  logic wake_s;
  logic [7:0] cmd_byte;
  logic cmd_valid;
  logic [15:0] frame;
  logic frame_done;
  logic [7:0] summary;
  logic [7:0] read_data;
  logic [6:0] frame_addr;
  logic frame_access;
  logic [7:0] frame_data;
  logic execute;
  logic [NUM_CTRL-1:0] ctrl_hit;
  logic [NUM_STAT-1:0] stat_hit;

  // Pin inputs pass two flip-flops
  pin_sync #(
    .W(4),
    .RESET_VAL(4'h2)
  ) u_pin_sync (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .async_in({wake_input_in, spi_sdi_in, spi_csn_n_in, spi_clk_in}),
    .sync_out(pins_sync)
  );

  assign sclk_s = pins_sync[0];
  assign csn_s = pins_sync[1];
  assign sdi_s = pins_sync[2];
  assign wake_s = pins_sync[3];

  // Serial framing and response shifting
  spi_frame_shifter u_shifter (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .sclk_in(sclk_s),
    .csn_n_in(csn_s),
    .sdi_in(sdi_s),
    .summary_in(summary),
    .data_in(read_data),
    .cmd_byte_out(cmd_byte),
    .cmd_valid_out(cmd_valid),
    .frame_out(frame),
    .frame_done_out(frame_done),
    .sdo_out(spi_sdo_out),
    .sdo_oe_out(spi_sdo_oe_out)
  );

  // Converts a transceiver field that is on into wake capable
  function automatic logic [1:0] sleep_field(input logic [1:0] field);
    sleep_field = (field == XCVR_ON) ? XCVR_WAKE : field;
  endfunction : sleep_field

  // Register read lookup for the response data byte
  function automatic logic [7:0] read_byte(
    input logic [6:0] addr,
    input logic [NUM_CTRL-1:0][7:0] ctrl,
    input logic [NUM_STAT-1:0][7:0] stat,
    input logic wake_level
  );
    logic [7:0] value;
    value = 8'h00;
    for (int i = 0; i < NUM_CTRL; i++) begin
      if (addr == CTRL_ADDRS[i]) begin
        value = ctrl[i] & CTRL_WMASKS[i];
      end
    end
    for (int i = 0; i < NUM_STAT; i++) begin
      if (addr == STAT_ADDRS[i]) begin
        value = stat[i] & STAT_MASKS[i];
      end
    end
    if (addr == WAKE_LEVEL_ADDR) begin
      value = {7'h00, wake_level};
    end
    if (addr == FAMILY_PRODUCT_ID_ADDR) begin
      value = FAMILY_PRODUCT_ID_VALUE;
    end
    read_byte = value;
  endfunction : read_byte

  genvar g;
  generate
    for (g = 0; g < NUM_STAT; g++) begin : g_summary
      assign summary[g] = |state_r.stat[g];
    end
  endgenerate

  // response uses stored, not pending, values
  assign read_data = cmd_valid ? read_byte(cmd_byte[ADDR_MSB:0], state_r.ctrl, state_r.stat,
                                           wake_s) : 8'h00;

  assign frame_addr = frame[ADDR_MSB:0];
  assign frame_access = frame[ACCESS_BIT];
  assign frame_data = frame[FRAME_BITS-1:DATA_LSB];

  assign execute = frame_done & ~device_quiet_in;

  // Address decode, window bounds checked as well
  generate
    for (g = 0; g < NUM_CTRL; g++) begin : g_ctrl_hit
      assign ctrl_hit[g] = execute && frame_access && (frame_addr == CTRL_ADDRS[g]) &&
                           (frame_addr >= CTRL_FIRST_ADDR) && (frame_addr <= CTRL_LAST_ADDR);
    end
    for (g = 0; g < NUM_STAT; g++) begin : g_stat_hit
      assign stat_hit[g] = execute && frame_access && (frame_addr == STAT_ADDRS[g]) &&
                           (frame_addr >= STAT_FIRST_ADDR) && (frame_addr <= STAT_LAST_ADDR);
    end
  endgenerate

  // Next-state of the whole register map
  always_comb begin
    state_nxt = state_r;
    state_nxt.mode_write = 1'b0;

    for (int i = 0; i < NUM_CTRL; i++) begin
      if (ctrl_hit[i]) begin
        state_nxt.ctrl[i] = (state_r.ctrl[i] & ~CTRL_WMASKS[i]) | (frame_data & CTRL_WMASKS[i]);
      end
    end
    if (ctrl_hit[CTRL_IDX_MODE]) begin
      state_nxt.mode_write = 1'b1;
      if (state_r.cur_mode != MODE_NORMAL) begin
        state_nxt.ctrl[CTRL_IDX_MODE][SUPPLY2_LSB +: 2] =
          state_r.ctrl[CTRL_IDX_MODE][SUPPLY2_LSB +: 2];
      end
    end

    // clear on access, new events win
    for (int i = 0; i < NUM_STAT; i++) begin
      state_nxt.stat[i] = ((stat_hit[i] ? 8'h00 : state_r.stat[i]) | status_event_in[i]) &
                          STAT_MASKS[i];
    end

    if (mode_change_in) begin
      state_nxt.cur_mode = mode_entered_in;
      state_nxt.ctrl[CTRL_IDX_MODE][MODE_LSB +: 2] = mode_entered_in;
      if (mode_entered_in == MODE_SLEEP) begin
        state_nxt.ctrl[CTRL_IDX_BUS1][CAN_LSB +: 2] =
          sleep_field(state_nxt.ctrl[CTRL_IDX_BUS1][CAN_LSB +: 2]);
        state_nxt.ctrl[CTRL_IDX_BUS1][LIN1_LSB +: 2] =
          sleep_field(state_nxt.ctrl[CTRL_IDX_BUS1][LIN1_LSB +: 2]);
        state_nxt.ctrl[CTRL_IDX_BUS2][LIN2_LSB +: 2] =
          sleep_field(state_nxt.ctrl[CTRL_IDX_BUS2][LIN2_LSB +: 2]);
      end
    end

    // fail latch untouched by mode change
    state_nxt.fail_latch = (state_r.fail_latch & ~fail_release_in) | fail_trigger_in;
  end

  // State register, all controls zero after reset
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= '{ctrl: {NUM_CTRL{CTRL_RESET}}, stat: {NUM_STAT{STAT_RESET}},
                   fail_latch: 1'b0, cur_mode: MODE_NORMAL, mode_write: 1'b0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign control_regs_out = state_r.ctrl;
  assign mode_write_out = state_r.mode_write;
  assign can_mode_out = state_r.ctrl[CTRL_IDX_BUS1][CAN_LSB +: 2];
  assign lin1_mode_out = state_r.ctrl[CTRL_IDX_BUS1][LIN1_LSB +: 2];
  assign lin2_mode_out = state_r.ctrl[CTRL_IDX_BUS2][LIN2_LSB +: 2];
  assign fail_outputs_out = state_r.fail_latch | state_r.ctrl[CTRL_IDX_HW][FAIL_SW_ON_BIT];
  assign summary_out = summary;

endmodule : sbc_spi_register_map

`default_nettype wire

// *** include/sbc_regs_pkg.sv ***
package sbc_regs_pkg;

  // Command frame layout
  localparam int FRAME_BITS = 16;
  localparam int ADDR_MSB = 6;
  localparam int ACCESS_BIT = 7;
  localparam int DATA_LSB = 8;
  localparam int BYTE_BITS = 8;
  localparam logic [4:0] FRAME_LEN = 5'h10;
  localparam logic [4:0] FIRST_BYTE_LEN = 5'h08;

  // Address windows
  localparam logic [6:0] CTRL_FIRST_ADDR = 7'h01;
  localparam logic [6:0] CTRL_LAST_ADDR = 7'h1E;
  localparam logic [6:0] STAT_FIRST_ADDR = 7'h41;
  localparam logic [6:0] STAT_LAST_ADDR = 7'h7E;

  // Control registers, index 0 to 9
  localparam int NUM_CTRL = 10;
  localparam int CTRL_IDX_MODE = 0;
  localparam int CTRL_IDX_HW = 1;
  localparam int CTRL_IDX_BUS1 = 3;
  localparam int CTRL_IDX_BUS2 = 4;
  localparam logic [NUM_CTRL-1:0][6:0] CTRL_ADDRS = {
    7'h1E, 7'h0C, 7'h08, 7'h07, 7'h06, 7'h05, 7'h04, 7'h03, 7'h02, 7'h01};
  localparam logic [NUM_CTRL-1:0][7:0] CTRL_WMASKS = {
    8'hFF, 8'h07, 8'h03, 8'h01, 8'h44, 8'h03, 8'hFB, 8'hFF, 8'hFF, 8'hDF};
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status registers, index equals summary bit
  localparam int NUM_STAT = 8;
  localparam logic [NUM_STAT-1:0][6:0] STAT_ADDRS = {
    7'h4C, 7'h47, 7'h46, 7'h45, 7'h44, 7'h43, 7'h42, 7'h41};
  localparam logic [NUM_STAT-1:0][7:0] STAT_MASKS = {
    8'hF7, 8'h03, 8'hB1, 8'h06, 8'h67, 8'hFF, 8'h07, 8'hFD};
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [6:0] WAKE_LEVEL_ADDR = 7'h48;
  localparam logic [6:0] FAMILY_PRODUCT_ID_ADDR = 7'h7E;
  // Identity value is arbitrary
  localparam logic [7:0] FAMILY_PRODUCT_ID_VALUE = 8'h5A;

  // Field positions
  localparam int MODE_LSB = 6;
  localparam int SUPPLY2_LSB = 3;
  localparam int FAIL_SW_ON_BIT = 5;
  localparam int CAN_LSB = 0;
  localparam int LIN1_LSB = 3;
  localparam int LIN2_LSB = 0;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_STOP = 2'b10,
    MODE_RESET = 2'b11
  } sbc_mode_e;

  // Transceiver field codes
  localparam logic [1:0] XCVR_OFF = 2'b00;
  localparam logic [1:0] XCVR_WAKE = 2'b01;
  localparam logic [1:0] XCVR_ON = 2'b11;

endpackage : sbc_regs_pkg

// *** rtl/pin_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } sync_s;

  sync_s state_r;
  sync_s state_nxt;

  // Two-stage chain; only stage two leaves the module
  always_comb begin
    state_nxt.stage1 = async_in;
    state_nxt.stage2 = state_r.stage1;
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= {RESET_VAL, RESET_VAL};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sync_out = state_r.stage2;

endmodule : pin_sync

`default_nettype wire

// *** rtl/spi_frame_shifter.sv ***
`timescale 1ns/10ps
`default_nettype none

module spi_frame_shifter (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic sclk_in,
  input wire logic csn_n_in,
  input wire logic sdi_in,
  input wire logic [7:0] summary_in,
  input wire logic [7:0] data_in,
  output logic [7:0] cmd_byte_out,
  output logic cmd_valid_out,
  output logic [15:0] frame_out,
  output logic frame_done_out,
  output logic sdo_out,
  output logic sdo_oe_out
);
  import sbc_regs_pkg::*;

  typedef struct packed {
    logic sclk_d;
    logic csn_d;
    logic [4:0] count;
    logic loaded;
    logic [FRAME_BITS-1:0] rx;
    logic [FRAME_BITS-1:0] tx;
    logic sdo;
    logic done;
  } shift_s;

  shift_s state_r;
  shift_s state_nxt;
  logic sclk_rise;
  logic sclk_fall;
  logic csn_fall;
  logic csn_rise;

  // Edge detection on synchronised pins
  assign sclk_rise = sclk_in & ~state_r.sclk_d & ~csn_n_in;
  assign sclk_fall = ~sclk_in & state_r.sclk_d & ~csn_n_in;
  assign csn_fall = ~csn_n_in & state_r.csn_d;
  assign csn_rise = csn_n_in & ~state_r.csn_d;

  // Shift in on falling, out on rising, LSB first
  always_comb begin
    state_nxt = state_r;
    state_nxt.sclk_d = sclk_in;
    state_nxt.csn_d = csn_n_in;
    state_nxt.done = 1'b0;
    if (csn_fall) begin
      state_nxt.count = 5'h00;
      state_nxt.loaded = 1'b0;
      state_nxt.tx = {8'h00, summary_in};
      state_nxt.sdo = 1'b0;
    end else if (csn_rise) begin
      // Only a frame of exactly sixteen clocks is executed
      state_nxt.done = (state_r.count == FRAME_LEN);
    end else begin
      if (sclk_fall) begin
        state_nxt.rx = {sdi_in, state_r.rx[FRAME_BITS-1:1]};
        if (state_r.count <= FRAME_LEN) begin
          state_nxt.count = state_r.count + 5'h01;
        end
      end
      if (sclk_rise) begin
        state_nxt.sdo = state_r.tx[0];
        state_nxt.tx = {1'b0, state_r.tx[FRAME_BITS-1:1]};
      end else if (state_r.count == FIRST_BYTE_LEN && !state_r.loaded) begin
        // Data byte follows once the address is known
        state_nxt.tx[BYTE_BITS-1:0] = data_in;
        state_nxt.loaded = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= '{sclk_d: 1'b0, csn_d: 1'b1, count: 5'h00, loaded: 1'b0,
                   rx: 16'h0000, tx: 16'h0000, sdo: 1'b0, done: 1'b0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign cmd_byte_out = state_r.rx[FRAME_BITS-1:BYTE_BITS];
  assign cmd_valid_out = (state_r.count == FIRST_BYTE_LEN);
  assign frame_out = state_r.rx;
  assign frame_done_out = state_r.done;
  assign sdo_out = state_r.sdo;
  assign sdo_oe_out = ~state_r.csn_d;

endmodule : spi_frame_shifter

`default_nettype wire

// *** tb/sbc_map_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module sbc_map_monitor (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic spi_csn_n_in,
  input wire logic device_quiet_in,
  input wire logic mode_change_in,
  input wire sbc_regs_pkg::sbc_mode_e mode_entered_in,
  input wire logic [sbc_regs_pkg::NUM_STAT-1:0][7:0] status_event_in,
  input wire logic fail_trigger_in,
  input wire logic spi_sdo_oe_out,
  input wire logic [sbc_regs_pkg::NUM_CTRL-1:0][7:0] control_regs_out,
  input wire logic [1:0] can_mode_out,
  input wire logic [1:0] lin1_mode_out,
  input wire logic fail_outputs_out,
  input wire logic [7:0] summary_out
);
  import sbc_regs_pkg::*;
  logic [7:0] ev;
  // Masked event flags
  always_comb begin
    for (int i = 0; i < NUM_STAT; i++) begin
      ev[i] = |(status_event_in[i] & STAT_MASKS[i]);
    end
  end
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  sequence csn_idle_s;
    spi_csn_n_in [*5];
  endsequence
  sequence to_sleep_s;
    mode_change_in && mode_entered_in == MODE_SLEEP;
  endsequence
  summary_set_a: assert property (|ev |=> (summary_out & $past(ev)) == $past(ev))
    else $error("summary bit missing");
  fail_set_a: assert property (fail_trigger_in |=> fail_outputs_out)
    else $error("fail output not set");
  // sleep turns can on to wake
  can_sleep_a: assert property (to_sleep_s ##0 can_mode_out == XCVR_ON |=>
    can_mode_out == XCVR_WAKE) else $error("can field not wake");
  // sleep turns lin on to wake
  lin_sleep_a: assert property (to_sleep_s ##0 lin1_mode_out == XCVR_ON |=>
    lin1_mode_out == XCVR_WAKE) else $error("lin field not wake");
  mode_field_a: assert property (mode_change_in |=>
    control_regs_out[0][7:6] == $past(mode_entered_in)) else $error("mode field wrong");
  sdo_release_a: assert property (csn_idle_s |-> !spi_sdo_oe_out)
    else $error("sdo driven while idle");
  // control regs change only by frames or mode changes
  ctrl_hold_a: assert property ((spi_csn_n_in && !mode_change_in) [*6] |=>
    $stable(control_regs_out)) else $error("control changed while idle");
  quiet_hold_a: assert property (device_quiet_in && !mode_change_in |=>
    $stable(control_regs_out)) else $error("control changed while quiet");
endmodule : sbc_map_monitor
bind sbc_spi_register_map sbc_map_monitor u_sbc_map_monitor (
  .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .spi_csn_n_in(spi_csn_n_in),
  .device_quiet_in(device_quiet_in), .mode_change_in(mode_change_in),
  .mode_entered_in(mode_entered_in), .status_event_in(status_event_in),
  .fail_trigger_in(fail_trigger_in), .spi_sdo_oe_out(spi_sdo_oe_out),
  .control_regs_out(control_regs_out), .can_mode_out(can_mode_out),
  .lin1_mode_out(lin1_mode_out), .fail_outputs_out(fail_outputs_out),
  .summary_out(summary_out));
`default_nettype wire

// *** tb/spi_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  input wire logic clk_sys_in,
  input wire logic spi_sdo_in,
  output logic spi_clk_out,
  output logic spi_csn_n_out,
  output logic spi_sdi_out
);
  // Idle link levels
  initial begin
    spi_clk_out = 1'b0;
    spi_csn_n_out = 1'b1;
    spi_sdi_out = 1'b0;
  end
  // Half link period, four system cycles
  task automatic half;
    repeat (4) @(negedge clk_sys_in);
  endtask : half
  // One frame of n clocks, bit 0 first
  task automatic xfer(input logic [15:0] f, input int n, output logic [15:0] r);
    spi_csn_n_out = 1'b0;
    half();
    for (int k = 0; k < n; k++) begin
      spi_clk_out = 1'b1;
      spi_sdi_out = f[k];
      half();
      spi_clk_out = 1'b0;
      half();
      r[k] = spi_sdo_in;
    end
    spi_csn_n_out = 1'b1;
    spi_sdi_out = ~spi_sdi_out; // No stale data bit
    repeat (10) @(negedge clk_sys_in);
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// *** tb/tb_sbc_spi_register_map.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_sbc_spi_register_map;
  import sbc_regs_pkg::*;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic sck, csn_n, sdi, sdo, sdo_oe, sdo_line, mw, fo;
  logic wake = 1'b0;
  logic quiet = 1'b0;
  logic mchg = 1'b0;
  sbc_mode_e ment = MODE_NORMAL;
  logic [NUM_STAT-1:0][7:0] sev = '0;
  logic ftrig = 1'b0;
  logic frel = 1'b0;
  logic [NUM_CTRL-1:0][7:0] ctrl;
  logic [1:0] can, lin1, lin2;
  logic [7:0] summ;
  logic [15:0] resp;
  int error_cnt = 0;
  int samples_checked = 0;
  int mw_cnt = 0;
  // Clock and released sdo line
  always #20 clk_sys_in = ~clk_sys_in;
  assign sdo_line = sdo_oe ? sdo : ~sdo;
  // Pulse counted away from the edge that launches it
  always @(negedge clk_sys_in) if (mw === 1'b1) mw_cnt++;
  sbc_spi_register_map u_sbc_spi_register_map (.clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in), .spi_clk_in(sck), .spi_csn_n_in(csn_n), .spi_sdi_in(sdi),
    .spi_sdo_out(sdo), .spi_sdo_oe_out(sdo_oe), .wake_input_in(wake),
    .device_quiet_in(quiet), .mode_change_in(mchg), .mode_entered_in(ment),
    .status_event_in(sev), .fail_trigger_in(ftrig), .fail_release_in(frel),
    .control_regs_out(ctrl), .mode_write_out(mw), .can_mode_out(can),
    .lin1_mode_out(lin1), .lin2_mode_out(lin2), .fail_outputs_out(fo), .summary_out(summ));
  spi_host_model u_spi_host_model (.clk_sys_in(clk_sys_in), .spi_sdo_in(sdo_line),
    .spi_clk_out(sck), .spi_csn_n_out(csn_n), .spi_sdi_out(sdi));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic frame(input logic [6:0] a, input logic acc, input logic [7:0] d);
    u_spi_host_model.xfer({d, acc, a}, 16, resp);
  endtask : frame
  task automatic enter(input sbc_mode_e m);
    ment = m;
    mchg = 1'b1;
    @(negedge clk_sys_in);
    mchg = 1'b0;
    @(negedge clk_sys_in);
  endtask : enter
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // Hang limit
  initial begin
    repeat (30000) @(posedge clk_sys_in);
    error_cnt++;
    give_verdict();
  end
  // Main sequence
  initial begin
    repeat (8) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    check("summary reset", summ, 8'h00);
    for (int i = 0; i < NUM_CTRL; i++) begin
      frame(CTRL_ADDRS[i], 1'b1, 8'hFF);
      check("old value", resp[15:8], CTRL_RESET);
      frame(CTRL_ADDRS[i], 1'b0, 8'h00);
      check("readback", resp[15:8], CTRL_WMASKS[i]);
      check("ctrl port", ctrl[i], CTRL_WMASKS[i]);
    end
    frame(7'h10, 1'b1, 8'hFF);
    frame(7'h10, 1'b0, 8'h00);
    check("unmapped", resp[15:8], 8'h00);
    frame(FAMILY_PRODUCT_ID_ADDR, 1'b1, 8'h00);
    check("identity", resp[15:8], FAMILY_PRODUCT_ID_VALUE);
    sev = {NUM_STAT{8'hFF}};
    @(negedge clk_sys_in);
    sev = '0;
    @(negedge clk_sys_in);
    check("summary set", summ, 8'hFF);
    for (int i = 0; i < NUM_STAT; i++) begin
      frame(STAT_ADDRS[i], 1'b0, 8'h00);
      check("status read", resp[15:8], STAT_MASKS[i]);
      check("summary byte", resp[7:0], 8'(8'hFF << i));
      frame(STAT_ADDRS[i], 1'b1, 8'h00);
      check("clear reply", resp[15:8], STAT_MASKS[i]);
    end
    check("summary clear", summ, 8'h00);
    wake = 1'b1;
    frame(WAKE_LEVEL_ADDR, 1'b1, 8'h00);
    check("wake clear reply", resp[15:8], 8'h01);
    frame(WAKE_LEVEL_ADDR, 1'b0, 8'h00);
    check("wake level", resp[15:8], 8'h01);
    frame(CTRL_ADDRS[CTRL_IDX_HW], 1'b1, 8'h00);
    check("fail idle", fo, 1'b0);
    ftrig = 1'b1;
    @(negedge clk_sys_in);
    ftrig = 1'b0;
    enter(MODE_SLEEP);
    check("can", can, XCVR_WAKE);
    check("lin1", lin1, XCVR_WAKE);
    check("lin2", lin2, XCVR_WAKE);
    check("fail kept", fo, 1'b1);
    check("mode field", ctrl[CTRL_IDX_MODE][7:6], MODE_SLEEP);
    quiet = 1'b1;
    frame(CTRL_ADDRS[9], 1'b1, 8'h00);
    quiet = 1'b0;
    check("quiet", ctrl[9], 8'hFF);
    // Frame cut after eight clocks is dropped
    u_spi_host_model.xfer({8'h00, 1'b1, CTRL_ADDRS[9]}, 8, resp);
    check("short frame", ctrl[9], 8'hFF);
    enter(MODE_STOP);
    frame(CTRL_ADDRS[CTRL_IDX_MODE], 1'b1, 8'h00);
    frame(CTRL_ADDRS[CTRL_IDX_MODE], 1'b0, 8'h00);
    check("supply kept", resp[15:8], 8'h18);
    enter(MODE_NORMAL);
    frame(CTRL_ADDRS[CTRL_IDX_MODE], 1'b1, 8'h08);
    frame(CTRL_ADDRS[CTRL_IDX_MODE], 1'b0, 8'h00);
    check("supply set", resp[15:8], 8'h08);
    check("mode writes", mw_cnt, 16'h0003);
    frel = 1'b1;
    @(negedge clk_sys_in);
    frel = 1'b0;
    @(negedge clk_sys_in);
    check("fail release", fo, 1'b0);
    // Mid-run reset returns controls to zero
    reset_n_in = 1'b0;
    repeat (2) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    check("ctrl after reset", ctrl[9], CTRL_RESET);
    check("summary after reset", summ, 8'h00);
    give_verdict();
  end
endmodule : tb_sbc_spi_register_map
`default_nettype wire
